// *** design/fvi_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Status bit 9 reads 1 while any interrupt is pending.
// - Status bit 8 reads 1 while any handler executes.
// - Nesting field reads 0x01 at one level, 0x03 at two.
// - Nesting field reads 0x00 when nothing is in service.
// - At most two nesting levels; no preemption beyond the second.
// - Two-level hardware context stack, one entry per nesting level.
// - Channel 0 and 1 numbers in bits 7:0 and 15:8, reset zero.
// - Channel 2 and 3 numbers in bits 23:16 and 31:24, reset zero.
// - Each channel keeps handler address bits 31:1 in its register.
// - Handler address bit 0 is forced to zero.
// - Address register bit 0 is the channel enable.
// - Disabled channel never redirects; enables reset to 0.
// - Status word read-only, reserved bits 31:10 read zero.
module fvi_top
  import fvi_pkg::*;
#(
  parameter int NUM_W = 8,
  parameter int CTX_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic irq_pending,
  input wire logic take_req,
  input wire logic [NUM_W-1:0] take_num,
  input wire logic [CTX_W-1:0] take_ctx,
  input wire logic ret_req,
  output logic take_ack,
  output logic take_fast,
  output logic [31:0] take_handler,
  output logic [NUM_W-1:0] take_num_out,
  output logic ret_ack,
  output logic [CTX_W-1:0] ret_ctx,
  output logic irq_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic [FVI_NUM_CH*NUM_W-1:0] num;
    logic [FVI_NUM_CH-1:0][31:0] addr;
    logic [1:0] depth;
    logic pend;
    logic ack;
    logic fast;
    logic [31:0] handler;
    logic [NUM_W-1:0] num_out;
    logic rack;
    logic rpop;
    logic [FVI_EVT_W-1:0] evt;
    logic [FVI_EVT_W-1:0] mask;
    logic irq;
  } fvi_state_t;

  fvi_state_t s_q, s_d;
  logic [CTX_W-1:0] ctx_rd;
  logic ctx_wr;
  logic [0:0] ctx_widx;
  logic [0:0] ctx_ridx;

  // ==========================================================
  // Context stack
  fvi_ctx_stack #(.WIDTH(CTX_W), .DEPTH(FVI_MAX_NEST)) u_ctx (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(ctx_wr),
    .wr_idx(ctx_widx),
    .wr_data(take_ctx),
    .rd_idx(ctx_ridx),
    .rd_data(ctx_rd)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] status;
    logic [7:0] nest;
    logic [FVI_EVT_W-1:0] evt_set;
    logic [FVI_EVT_W-1:0] evt_clr;
    logic hit;
    logic [31:0] hit_addr;
    logic [NUM_W-1:0] chnum;
    logic accept;
    logic [11:0] off;
    s_d = s_q;
    status = FVI_RST_WORD;
    nest = FVI_NEST_NONE;
    evt_set = '0;
    evt_clr = '0;
    hit = 1'b0;
    hit_addr = 32'h0000_0000;
    chnum = '0;
    accept = 1'b0;
    off = haddr[11:0];
    ctx_wr = 1'b0;
    ctx_widx = 1'b0;
    // Keep the popped slot addressed so its data still stand with the ack
    ctx_ridx = 1'(s_q.depth);

    case (s_q.depth)
      2'd1: nest = FVI_NEST_ONE;
      2'd2: nest = FVI_NEST_TWO;
      default: nest = FVI_NEST_NONE;
    endcase
    status[FVI_BIT_PEND] = s_q.pend;
    status[FVI_BIT_ACT] = (s_q.depth != 2'd0);
    status[7:0] = nest;

    s_d.pend = irq_pending;
    s_d.ack = 1'b0;
    s_d.rack = 1'b0;
    s_d.rpop = 1'b0;

    // Lowest channel wins if two share a number
    for (int i = FVI_NUM_CH - 1; i >= 0; i--) begin
      chnum = s_q.num[i*NUM_W +: NUM_W];
      if (s_q.addr[i][0] && chnum == take_num) begin
        hit = 1'b1;
        hit_addr = {s_q.addr[i][31:1], 1'b0};
      end
    end

    // Entry and return; return takes priority to keep the stack sane
    if (ret_req && s_q.depth != 2'd0) begin
      ctx_ridx = 1'(s_q.depth - 2'd1);
      s_d.depth = s_q.depth - 2'd1;
      s_d.rpop = 1'b1;
    end else if (take_req) begin
      if (s_q.depth < 2'(FVI_MAX_NEST)) begin
        accept = 1'b1;
        ctx_wr = 1'b1;
        ctx_widx = 1'(s_q.depth);
        s_d.depth = s_q.depth + 2'd1;
        s_d.ack = 1'b1;
        s_d.fast = hit;
        s_d.handler = hit ? hit_addr : 32'h0000_0000;
        s_d.num_out = take_num;
        evt_set[FVI_EVT_TAKE] = 1'b1;
        evt_set[FVI_EVT_FAST] = hit;
      end else begin
        evt_set[FVI_EVT_DENY] = 1'b1;
      end
    end
    // Stack read data lag one cycle behind the pop
    if (s_q.rpop) begin
      s_d.rack = 1'b1;
    end

    // Bus address phase
    if (hsel && hready && htrans[1]) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = off;
      if (!hwrite) begin
        case ({off[11:2], 2'b00})
          FVI_OFF_STATUS: s_d.rdata = status;
          FVI_OFF_IRQNUM: s_d.rdata = s_q.num;
          FVI_OFF_FAST0_HANDLER_ADDRESS: s_d.rdata = s_q.addr[0];
          FVI_OFF_FAST1_HANDLER_ADDRESS: s_d.rdata = s_q.addr[1];
          FVI_OFF_FAST2_HANDLER_ADDRESS: s_d.rdata = s_q.addr[2];
          FVI_OFF_FAST3_HANDLER_ADDRESS: s_d.rdata = s_q.addr[3];
          FVI_OFF_EVT_STAT: s_d.rdata = 32'(s_q.evt);
          FVI_OFF_EVT_MASK: s_d.rdata = 32'(s_q.mask);
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end else if (hready) begin
      s_d.wr_pend = 1'b0;
    end

    // Bus data phase write; status offset has no case
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      case ({s_q.wr_addr[11:2], 2'b00})
        FVI_OFF_IRQNUM: s_d.num = hwdata[FVI_NUM_CH*NUM_W-1:0];
        FVI_OFF_FAST0_HANDLER_ADDRESS: s_d.addr[0] = hwdata;
        FVI_OFF_FAST1_HANDLER_ADDRESS: s_d.addr[1] = hwdata;
        FVI_OFF_FAST2_HANDLER_ADDRESS: s_d.addr[2] = hwdata;
        FVI_OFF_FAST3_HANDLER_ADDRESS: s_d.addr[3] = hwdata;
        FVI_OFF_EVT_STAT: evt_clr = hwdata[FVI_EVT_W-1:0];
        FVI_OFF_EVT_MASK: s_d.mask = hwdata[FVI_EVT_W-1:0];
        default: ;
      endcase
    end

    // Set wins over a simultaneous write-one clear
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;
    s_d.irq = |(s_d.evt & s_d.mask);
    if (!accept) begin
      s_d.fast = s_q.fast;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign take_ack = s_q.ack;
  assign take_fast = s_q.fast;
  assign take_handler = s_q.handler;
  assign take_num_out = s_q.num_out;
  assign ret_ack = s_q.rack;
  assign ret_ctx = ctx_rd;
  assign irq_out = s_q.irq;

endmodule
`default_nettype wire

// *** design/fvi_pkg.sv ***
package fvi_pkg;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [11:0] FVI_OFF_STATUS = 12'h048;
  localparam logic [11:0] FVI_OFF_IRQNUM = 12'h050;
  localparam logic [11:0] FVI_OFF_FAST0_HANDLER_ADDRESS = 12'h060;
  localparam logic [11:0] FVI_OFF_FAST1_HANDLER_ADDRESS = 12'h064;
  localparam logic [11:0] FVI_OFF_FAST2_HANDLER_ADDRESS = 12'h068;
  localparam logic [11:0] FVI_OFF_FAST3_HANDLER_ADDRESS = 12'h06c;
  localparam logic [11:0] FVI_OFF_EVT_STAT = 12'h070;
  localparam logic [11:0] FVI_OFF_EVT_MASK = 12'h074;

  // ==========================================================
  // Field positions and values
  localparam int FVI_BIT_PEND = 9;
  localparam int FVI_BIT_ACT = 8;
  localparam logic [7:0] FVI_NEST_NONE = 8'h00;
  localparam logic [7:0] FVI_NEST_ONE = 8'h01;
  localparam logic [7:0] FVI_NEST_TWO = 8'h03;
  localparam int FVI_NUM_CH = 4;
  localparam int FVI_MAX_NEST = 2;
  localparam logic [31:0] FVI_RST_WORD = 32'h0000_0000;

  // Event bits in the sticky status word
  localparam int FVI_EVT_TAKE = 0;
  localparam int FVI_EVT_FAST = 1;
  localparam int FVI_EVT_DENY = 2;
  localparam int FVI_EVT_W = 3;

endpackage

// *** design/fvi_ctx_stack.sv ***
`timescale 1ns/1ns
`default_nettype none
// Two-entry context store; read data come out of a register
module fvi_ctx_stack #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (wr_en) begin
        mem_q[wr_idx] <= wr_data;
      end
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule
`default_nettype wire

// *** verification/fvi_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module fvi_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic take_req,
  input wire logic ret_req,
  input wire logic take_ack,
  input wire logic take_fast,
  input wire logic [31:0] take_handler,
  input wire logic ret_ack
);
  // ==========================================
  // Depth mirror; a return wins over a take
  logic [1:0] dep_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dep_q <= 2'h0;
    else if (ret_req && dep_q != 2'h0) dep_q <= dep_q - 2'h1;
    else if (take_req && dep_q < 2'h2) dep_q <= dep_q + 2'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================
  // Checks
  AST_ACK: assert property (take_req && !ret_req && dep_q < 2'h2 |=> take_ack)
    else $error("take not acked");
  AST_DENY: assert property (take_req && dep_q == 2'h2 |=> !take_ack)
    else $error("third level acked");
  AST_ACKC: assert property (take_ack |-> $past(take_req))
    else $error("ack without take");
  AST_RET: assert property (ret_req && dep_q != 2'h0 |=> ##1 ret_ack)
    else $error("return not acked");
  AST_RETC: assert property (ret_ack |-> $past(ret_req, 2))
    else $error("return ack without return");
  AST_BIT0: assert property (take_handler[0] == 1'h0)
    else $error("handler bit 0 set");
  AST_NOFAST: assert property (!take_fast |-> take_handler == 32'h0)
    else $error("handler without fast hit");
  AST_HOLD: assert property (!take_ack |-> $stable(take_handler) && $stable(take_fast))
    else $error("vector changed without accept");
endmodule
bind fvi_top fvi_props u_props (.*);
`default_nettype wire

// *** verification/fvi_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fvi_core_model (
  input wire logic hclk,
  input wire logic go_take,
  input wire logic go_ret,
  input wire logic [7:0] num,
  input wire logic take_ack,
  input wire logic ret_ack,
  input wire logic [31:0] ret_ctx,
  output logic take_req = 1'h0,
  output logic ret_req = 1'h0,
  output logic [7:0] take_num = 8'h0,
  output logic [31:0] take_ctx = 32'h0,
  output int mbad = 0
);
  logic [31:0] stk [$];
  logic [31:0] sent = 32'h0;
  always @(posedge hclk) begin
    take_req <= go_take;
    ret_req <= go_ret;
    // Idle lines toggle so a stale value never looks valid
    take_num <= go_take ? num : ~take_num;
    take_ctx <= go_take ? {24'h5a5a5a, num} : ~take_ctx;
    sent <= take_ctx;
    if (ret_ack) begin
      if (ret_ctx !== stk[$]) mbad <= mbad + 1;
      void'(stk.pop_back());
    end
    if (take_ack) stk.push_back(sent);
  end
endmodule
`default_nettype wire

// *** verification/fast_vector_irq_status_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module fast_vector_irq_status_tb
  import fvi_pkg::*;
;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, irq_pending = 1'h0;
  logic go_take = 1'h0, go_ret = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [7:0] num = 8'h0, take_num, take_num_out;
  logic hreadyout, hresp, take_req, ret_req, take_ack, take_fast, ret_ack, irq_out;
  logic [31:0] hrdata, take_ctx, take_handler, ret_ctx;
  wire logic hready = hreadyout;
  int mbad, bad_count = 0, n_tests = 0;
  fvi_top DUT (.*);
  fvi_core_model u_core (.*);
  initial begin
    forever #10 hclk = ~hclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // ==========================================
  // Bus master: wait on hready, bounded
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wt;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xf(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xf(1'h0, a, 32'h0, r);
    ck(r, e);
  endtask
  // Take (t=1) or return (t=0) through the core model
  task automatic pk(input logic t, input logic [7:0] v);
    go_take <= t;
    go_ret <= !t;
    num <= v;
    @(posedge hclk);
    go_take <= 1'h0;
    go_ret <= 1'h0;
    repeat (4) @(posedge hclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic s_regs;
    logic [11:0] offs [6];
    offs = '{FVI_OFF_STATUS, FVI_OFF_IRQNUM, FVI_OFF_FAST0_HANDLER_ADDRESS, FVI_OFF_FAST1_HANDLER_ADDRESS,
      FVI_OFF_FAST2_HANDLER_ADDRESS, FVI_OFF_FAST3_HANDLER_ADDRESS};
    foreach (offs[i]) rd(offs[i], FVI_RST_WORD);
    wr(FVI_OFF_IRQNUM, 32'h4433_2211);
    rd(FVI_OFF_IRQNUM, 32'h4433_2211);
    for (int i = 0; i < 4; i++) begin
      wr(FVI_OFF_FAST0_HANDLER_ADDRESS + 12'(4 * i), 32'hf0f0_0001 + 32'(i << 1));
      rd(FVI_OFF_FAST0_HANDLER_ADDRESS + 12'(4 * i), 32'hf0f0_0001 + 32'(i << 1));
    end
    wr(FVI_OFF_STATUS, 32'hffff_ffff);
    rd(FVI_OFF_STATUS, FVI_RST_WORD);
    rd(12'h100, 32'h0);
    ck({31'h0, hresp}, 32'h0);
  endtask
  task automatic s_pend;
    irq_pending <= 1'h1;
    repeat (2) @(posedge hclk);
    rd(FVI_OFF_STATUS, 32'h0000_0200);
    irq_pending <= 1'h0;
    repeat (2) @(posedge hclk);
    rd(FVI_OFF_STATUS, FVI_RST_WORD);
  endtask
  task automatic s_fast;
    wr(FVI_OFF_IRQNUM, 32'h0022_1111);
    wr(FVI_OFF_FAST0_HANDLER_ADDRESS, 32'h0000_3000);
    wr(FVI_OFF_FAST1_HANDLER_ADDRESS, 32'h0000_2003);
    wr(FVI_OFF_FAST2_HANDLER_ADDRESS, 32'h0000_4000);
    pk(1'h1, 8'h11);
    ck(take_handler, 32'h0000_2002);
    ck({31'h0, take_fast}, 32'h1);
    rd(FVI_OFF_STATUS, 32'h0000_0101);
    pk(1'h1, 8'h22);
    ck(take_handler, 32'h0);
    rd(FVI_OFF_STATUS, 32'h0000_0103);
    pk(1'h1, 8'h33);
    ck({24'h0, take_num_out}, 32'h22);
    rd(FVI_OFF_STATUS, 32'h0000_0103);
    rd(FVI_OFF_EVT_STAT, 32'h7);
    ck({31'h0, irq_out}, 32'h0);
    wr(FVI_OFF_EVT_MASK, 32'h4);
    rd(FVI_OFF_EVT_MASK, 32'h4);
    ck({31'h0, irq_out}, 32'h1);
    wr(FVI_OFF_EVT_STAT, 32'h7);
    rd(FVI_OFF_EVT_STAT, 32'h0);
    ck({31'h0, irq_out}, 32'h0);
    pk(1'h0, 8'h0);
    rd(FVI_OFF_STATUS, 32'h0000_0101);
    pk(1'h0, 8'h0);
    rd(FVI_OFF_STATUS, FVI_RST_WORD);
    ck(32'(mbad), 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    s_regs;
    s_pend;
    s_fast;
    end_sim;
  end
endmodule
`default_nettype wire
